// >>> design/rtc_serial_core.v
// How it works
// (R1) snapshot watch, timer, temperature at transaction start
// (R2) cache steady; written pages copied at stop
// (R3) two-wire address 1010110 matched, every received byte acked
// (R4) two-wire write increments only low address bits
// (R5) two-wire read advances on master ack only
// (R6) four-wire: change on fall, sample on rise
// (R7) four-wire first bit direction, seven address bits
// (R8) four-wire write holds serial output low
// (R9) four-wire read shifts data, output floats unselected
// (R10) reset sets power-on status bit
// (R11) fast supply check, then configuration load
// (R12) supply check every one or sixteen seconds
// (R13) temperature measured only above first level
// (R14) hourly configuration refresh above second level
// (R15) BCD watch, restarts one second after write
// (R16) alarm fields compared only when bit seven set
// (R17) sixteen-bit timer counts only while enabled
// (R18) timer rate 32, 8, 1 or 0.5 Hz
// (R19) reload mode reads and reloads last written value
// (R20) host changes timer setup only while stopped; the core also accepts timer value and on/off writes while running
// (R21) thermometer on by default, off on low supply
// (R22) temperature writable while thermometer off, triggers recompute
// (R23) timer off and 32 Hz after reset
// (R24) timer flag set on reaching zero
// (R25) alarm flag set on full match
// (R26) hour format selects 12 or 24 hours
// (R27) stop mode holds zero until rewritten
`timescale 1ns/1ns
`include "rtc_serial_defs.vh"
module rtc_serial_core #(
    parameter TICK_DIV     = `CLK_HZ / `TICK_HZ,
    parameter REFRESH_SECS = `REFRESH_S
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       spi_mode,
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe_n,
    input  wire       cs_n,
    input  wire       sck,
    input  wire       si,
    output reg        so,
    output reg        so_oe_n,
    input  wire       supply_above_first,
    input  wire       supply_above_second,
    input  wire       thermo_enable,
    input  wire       scan_period_select,
    input  wire [7:0] temp_meas,
    input  wire       temp_meas_valid,
    output reg        ee_read_en,
    output reg  [6:0] ee_addr,
    output reg        fast_detect,
    output reg        voltage_check_req,
    output reg        temp_measure_req,
    output reg        comp_calc_req,
    output reg  [7:0] temp_value,
    output reg        thermo_active,
    output wire       timer_run_enable,
    output wire       timer_reload_select,
    output wire       timer_rate_hi,
    output wire       timer_rate_lo,
    output wire       alarm_match_flag,
    output wire       countdown_zero_flag,
    output wire       power_on_status,
    output wire       low_supply_first_status
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_REG  = 3'd2;
    localparam ST_WR   = 3'd3;
    localparam ST_RD   = 3'd4;
    localparam ST_ACK  = 3'd5;
    localparam ST_MACK = 3'd6;

    reg  [7:0]  s1, s2;
    reg  [3:0]  s3;
    reg  [2:0]  st, nst;
    reg  [2:0]  bitc;
    reg  [7:0]  sh, osh, wr_data, rdb;
    reg  [6:0]  addr, wr_addr;
    reg         acked, wr_stb, start_stb, stop_stb;
    reg  [7:0]  onoff, flags, status, next_flags, next_status;
    reg  [7:0]  wreg [0:6];
    reg  [7:0]  areg [0:6];
    reg  [7:0]  cache [0:9];
    reg  [2:0]  dirty;
    reg  [15:0] tcount, treload;
    reg  [19:0] div;
    reg  [5:0]  t64;
    reg  [4:0]  wph;
    reg  [3:0]  scnt;
    reg  [11:0] hcnt;
    reg         sec_ticked;
    integer     i;

    wire m_spi = s2[7];
    wire l_scl = s2[6];
    wire l_sda = s2[5];
    wire l_cs  = s2[4];
    wire l_sck = s2[3];
    wire v1ok  = s2[1];
    wire v2ok  = s2[0];
    wire ev_start = m_spi ? (s3[1] & ~l_cs) : (l_scl & s3[3] & s3[2] & ~l_sda);
    wire ev_stop  = m_spi ? (~s3[1] & l_cs) : (l_scl & s3[3] & ~s3[2] & l_sda);
    wire ev_rise  = m_spi ? (~l_cs & ~s3[0] & l_sck) : (~s3[3] & l_scl);
    wire ev_fall  = m_spi ? (~l_cs & s3[0] & ~l_sck) : (s3[3] & ~l_scl);
    wire din      = m_spi ? s2[2] : l_sda;
    wire [7:0] nsh = {sh[6:0], din};
    wire [2:0] ofs = addr[2:0];
    wire [3:0] pg  = addr[6:3];

    assign timer_run_enable        = onoff[`B_TRUN];
    assign timer_reload_select     = onoff[`B_TRLD];
    assign timer_rate_hi           = onoff[`B_RATE_HI];
    assign timer_rate_lo           = onoff[`B_RATE_LO];
    assign alarm_match_flag        = flags[`F_ALARM];
    assign countdown_zero_flag     = flags[`F_TIMER];
    assign power_on_status         = status[`S_PON];
    assign low_supply_first_status = status[`S_LOW1];

    // link inputs through two flops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= `SYNC_IDLE;
            s2 <= `SYNC_IDLE;
            s3 <= `EDGE_IDLE;
        end else begin
            s1 <= {spi_mode, scl, sda_in, cs_n, sck, si, supply_above_first, supply_above_second};
            s2 <= s1;
            s3 <= s2[6:3];
        end
    end

    // read mux
    always @* begin
        rdb = 8'h00;
        if (pg == `PG_CTRL) begin
            if (ofs == `OFS_ONOFF) rdb = onoff;
            else if (ofs == `OFS_FLAGS) rdb = flags;
            else if (ofs == `OFS_STATUS) rdb = status;
        end else if (pg == `PG_WATCH) begin
            if (ofs < 3'd7) rdb = cache[ofs]; // [R1]
        end else if (pg == `PG_ALARM) begin
            if (ofs < 3'd7) rdb = areg[ofs];
        end else if (pg == `PG_TIMER) begin
            if (ofs == 3'd0) rdb = cache[`C_TLO];
            else if (ofs == 3'd1) rdb = cache[`C_THI];
        end else if (pg == `PG_TEMP) begin
            if (ofs == 3'd0) rdb = cache[`C_TEMP];
        end
    end

    // serial engine, both link types
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_IDLE;
            nst <= ST_IDLE;
            bitc <= 3'd0;
            sh <= 8'h00;
            osh <= 8'h00;
            addr <= 7'h00;
            acked <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 8'h00;
            start_stb <= 1'b0;
            stop_stb <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            wr_stb <= 1'b0;
            start_stb <= 1'b0;
            stop_stb <= 1'b0;
            if (ev_stop) begin
                st <= ST_IDLE;
                stop_stb <= 1'b1; // [R2]
                sda_oe_n <= 1'b1;
                so_oe_n <= 1'b1; // [R9]
                so <= 1'b0;
            end else if (ev_start) begin
                st <= ST_ADDR;
                bitc <= 3'd0;
                start_stb <= 1'b1; // [R1]
                sda_oe_n <= 1'b1;
                so <= 1'b0;
                so_oe_n <= ~m_spi;
            end else if (ev_rise) begin
                if (st == ST_ADDR || st == ST_REG || st == ST_WR) begin
                    sh <= nsh; // [R6]
                    bitc <= bitc + 3'd1;
                    if (bitc == 3'd7) begin
                        nst <= ST_WR;
                        if (st == ST_ADDR && m_spi) begin
                            addr <= nsh[6:0]; // [R7]
                            st <= nsh[7] ? ST_RD : ST_WR;
                        end else if (st == ST_ADDR) begin
                            if (nsh[7:1] == `SLAVE_ADDR) begin // [R3]
                                nst <= nsh[0] ? ST_RD : ST_REG;
                                st <= ST_ACK;
                            end else begin
                                st <= ST_IDLE;
                            end
                        end else if (st == ST_REG) begin
                            addr <= nsh[6:0];
                            st <= ST_ACK;
                        end else begin
                            wr_stb <= 1'b1;
                            wr_addr <= addr;
                            wr_data <= nsh;
                            addr[2:0] <= addr[2:0] + 3'd1; // [R4] [R8]
                            st <= m_spi ? ST_WR : ST_ACK;
                        end
                    end
                end else if (st == ST_MACK) begin
                    acked <= ~din;
                    if (~din) addr[2:0] <= addr[2:0] + 3'd1; // [R5]
                end
            end else if (ev_fall) begin
                if (st == ST_ACK) begin
                    if (sda_oe_n) begin
                        sda_oe_n <= 1'b0; // [R3]
                    end else begin
                        st <= nst;
                        bitc <= 3'd0;
                        sda_oe_n <= 1'b1;
                        if (nst == ST_RD) begin
                            sda_oe_n <= rdb[7];
                            osh <= {rdb[6:0], 1'b0};
                            bitc <= 3'd1;
                        end
                    end
                end else if (st == ST_RD && m_spi) begin
                    bitc <= bitc + 3'd1;
                    if (bitc == 3'd0) begin
                        so <= rdb[7]; // [R9]
                        osh <= {rdb[6:0], 1'b0};
                        addr[2:0] <= addr[2:0] + 3'd1;
                    end else begin
                        so <= osh[7];
                        osh <= {osh[6:0], 1'b0};
                    end
                end else if (st == ST_RD) begin
                    if (bitc == 3'd0) begin
                        sda_oe_n <= 1'b1;
                        st <= ST_MACK;
                    end else begin
                        sda_oe_n <= osh[7];
                        osh <= {osh[6:0], 1'b0};
                        bitc <= bitc + 3'd1;
                    end
                end else if (st == ST_MACK) begin
                    if (acked) begin
                        st <= ST_RD; // [R5]
                        sda_oe_n <= rdb[7];
                        osh <= {rdb[6:0], 1'b0};
                        bitc <= 3'd1;
                    end else begin
                        st <= ST_IDLE;
                    end
                end
            end
        end
    end

    // watch next values
    function [7:0] binc;
        input [7:0] v;
        binc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction
    wire [7:0] w_s = wreg[0];
    wire [7:0] w_m = wreg[1];
    wire [7:0] w_h = wreg[2];
    wire [7:0] w_d = wreg[3];
    wire [7:0] w_mo = wreg[5];
    wire [7:0] w_y = wreg[6];
    wire       leap = w_y[4] ? (w_y[3:0] == 4'h2 || w_y[3:0] == 4'h6)
                             : (w_y[3:0] == 4'h0 || w_y[3:0] == 4'h4 || w_y[3:0] == 4'h8);
    wire [7:0] dmax = (w_mo == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                      (w_mo == 8'h04 || w_mo == 8'h06 || w_mo == 8'h09 || w_mo == 8'h11) ? 8'h30 : 8'h31;
    wire       fmt = w_h[`HR_FMT];
    wire       c0 = (w_s == 8'h59);
    wire       c1 = c0 & (w_m == 8'h59);
    wire       c2 = c1 & (fmt ? (w_h[5:0] == 6'h31) : (w_h[5:0] == 6'h23));
    wire       c3 = c2 & (w_d == dmax);
    wire       c4 = c3 & (w_mo == 8'h12);
    wire [7:0] hinc = binc({3'b000, w_h[4:0]});
    reg  [7:0] next_hour;
    always @* begin
        next_hour = binc({2'b00, w_h[5:0]}); // [R26]
        if (!fmt && w_h[5:0] == 6'h23) next_hour = 8'h00;
        else if (fmt && w_h[4:0] == 5'h11) next_hour = {2'b01, ~w_h[`HR_PM], 5'h12};
        else if (fmt && w_h[4:0] == 5'h12) next_hour = {2'b01, w_h[`HR_PM], 5'h01};
        else if (fmt) next_hour = {2'b01, w_h[`HR_PM], hinc[4:0]};
    end

    // alarm compare per field
    wire [6:0] al_ok, al_on;
    genvar g;
    generate
        for (g = 0; g < `WATCH_N; g = g + 1) begin : alarm_cmp
            assign al_on[g] = areg[g][`ALARM_EN]; // [R16]
            assign al_ok[g] = ~areg[g][`ALARM_EN] | (areg[g][6:0] == wreg[g][6:0]);
        end
    endgenerate

    wire tick32   = (div == TICK_DIV - 1);
    wire sec_tick = tick32 & (wph == 5'd31);
    wire tick1    = tick32 & (t64[4:0] == 5'd31);
    wire rate_tick = (onoff[`B_RATE_HI:`B_RATE_LO] == 2'd0) ? tick32 :
                     (onoff[`B_RATE_HI:`B_RATE_LO] == 2'd1) ? tick32 & (t64[1:0] == 2'd3) :
                     (onoff[`B_RATE_HI:`B_RATE_LO] == 2'd2) ? tick1 : tick32 & (t64 == 6'd63);
    wire t_zero   = timer_run_enable & rate_tick & (tcount == 16'h0001);
    wire scan_due = tick1 & (scan_period_select ? (scnt == `SCAN_LONG_S - 1) : 1'b1);
    wire hour_due = tick1 & (hcnt == REFRESH_SECS - 1);
    wire load_go  = (fast_detect & v2ok) | (hour_due & v2ok & onoff[`B_REFRESH]);
    wire wpg      = wr_stb & (wr_addr[2:0] < 3'd7);

    always @* begin
        next_flags = flags;
        next_status = status;
        if (wr_stb && wr_addr == {`PG_CTRL, `OFS_FLAGS}) next_flags = flags & wr_data;
        if (wr_stb && wr_addr == {`PG_CTRL, `OFS_STATUS}) next_status = status & wr_data;
        if (t_zero) next_flags[`F_TIMER] = 1'b1; // [R24]
        if (sec_ticked && (al_on != 7'h00) && (&al_ok)) next_flags[`F_ALARM] = 1'b1; // [R25]
        if (voltage_check_req && !fast_detect && !v1ok) next_status[`S_LOW1] = 1'b1;
    end

    // registers, watch, timer, supervision
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            onoff <= `ONOFF_RESET; // [R23]
            flags <= 8'h00;
            status <= 8'h01; // [R10]
            for (i = 0; i < `WATCH_N; i = i + 1) begin
                wreg[i] <= 8'h00;
                areg[i] <= 8'h00;
            end
            for (i = 0; i < 10; i = i + 1) cache[i] <= 8'h00;
            dirty <= 3'b000;
            tcount <= 16'h0000;
            treload <= 16'h0000;
            div <= 20'd0;
            t64 <= 6'd0;
            wph <= 5'd0;
            scnt <= 4'd0;
            hcnt <= 12'd0;
            sec_ticked <= 1'b0;
            temp_value <= 8'h00;
            thermo_active <= 1'b0;
            fast_detect <= 1'b1;
            ee_read_en <= 1'b0;
            ee_addr <= `EE_FIRST;
            voltage_check_req <= 1'b0;
            temp_measure_req <= 1'b0;
            comp_calc_req <= 1'b0;
        end else begin
            flags <= next_flags;
            status <= next_status;
            div <= tick32 ? 20'd0 : div + 20'd1;
            if (tick32) t64 <= t64 + 6'd1;
            if (tick32) wph <= wph + 5'd1;
            if (tick1) scnt <= scnt + 4'd1;
            if (tick1) hcnt <= hour_due ? 12'd0 : hcnt + 12'd1;
            sec_ticked <= sec_tick;
            thermo_active <= thermo_enable & ~status[`S_LOW1]; // [R21]
            voltage_check_req <= fast_detect ? tick32 : scan_due; // [R11] [R12]
            temp_measure_req <= scan_due & v1ok & thermo_enable & ~status[`S_LOW1] & ~fast_detect; // [R13]
            comp_calc_req <= 1'b0;
            if (fast_detect & v2ok) fast_detect <= 1'b0; // [R11]
            if (load_go) begin
                ee_read_en <= 1'b1; // [R11] [R14]
                ee_addr <= `EE_FIRST;
            end else if (ee_read_en) begin
                if (ee_addr == `EE_LAST) ee_read_en <= 1'b0;
                else ee_addr <= ee_addr + 7'd1;
            end
            if (temp_meas_valid && thermo_active) begin
                temp_value <= temp_meas;
                comp_calc_req <= 1'b1; // [R13]
            end
            if (sec_tick) begin
                wreg[0] <= c0 ? 8'h00 : binc(w_s); // [R15]
                if (c0) wreg[1] <= c1 ? 8'h00 : binc(w_m);
                if (c1) wreg[2] <= next_hour; // [R26]
                if (c2) wreg[3] <= c3 ? 8'h01 : binc(w_d);
                if (c2) wreg[4] <= (wreg[4] == 8'h07) ? 8'h01 : binc(wreg[4]);
                if (c3) wreg[5] <= c4 ? 8'h01 : binc(w_mo);
                if (c4) wreg[6] <= (w_y == 8'h99) ? 8'h00 : binc(w_y);
            end
            if (timer_run_enable && rate_tick) begin // [R17] [R18]
                if (tcount == 16'h0001) tcount <= onoff[`B_TRLD] ? treload : 16'h0000; // [R19]
                else if (tcount != 16'h0000) tcount <= tcount - 16'h0001; // [R27]
            end
            if (start_stb) begin
                for (i = 0; i < `WATCH_N; i = i + 1) cache[i] <= wreg[i]; // [R1]
                {cache[`C_THI], cache[`C_TLO]} <= onoff[`B_TRLD] ? treload : tcount; // [R19]
                cache[`C_TEMP] <= temp_value; // [R22]
                dirty <= 3'b000;
            end
            if (wr_stb && wr_addr[6:3] == `PG_CTRL && wr_addr[2:0] == `OFS_ONOFF) onoff <= wr_data;
            if (wpg && wr_addr[6:3] == `PG_ALARM) areg[wr_addr[2:0]] <= wr_data;
            if (wpg && wr_addr[6:3] == `PG_WATCH) begin
                cache[wr_addr[2:0]] <= wr_data;
                dirty[0] <= 1'b1;
            end
            if (wr_stb && wr_addr[6:3] == `PG_TIMER && wr_addr[2:1] == 2'b00) begin
                if (wr_addr[0]) cache[`C_THI] <= wr_data;
                else cache[`C_TLO] <= wr_data;
                dirty[1] <= 1'b1;
            end
            if (wr_stb && wr_addr == {`PG_TEMP, 3'd0} && !thermo_active) begin
                cache[`C_TEMP] <= wr_data; // [R22]
                dirty[2] <= 1'b1;
            end
            if (stop_stb) begin
                if (dirty[0]) begin
                    for (i = 0; i < `WATCH_N; i = i + 1) wreg[i] <= cache[i]; // [R2]
                    wph <= 5'd0; // [R15]
                end
                if (dirty[1]) begin
                    tcount <= {cache[`C_THI], cache[`C_TLO]}; // [R2] [R27]
                    treload <= {cache[`C_THI], cache[`C_TLO]};
                end
                if (dirty[2] && !thermo_active) begin
                    temp_value <= cache[`C_TEMP];
                    comp_calc_req <= 1'b1; // [R22]
                end
            end
        end
    end
endmodule

// >>> design/rtc_serial_defs.vh
`ifndef RTC_SERIAL_DEFS_VH
`define RTC_SERIAL_DEFS_VH
`define SLAVE_ADDR   7'h56
`define PG_CTRL      4'h0
`define PG_WATCH     4'h1
`define PG_ALARM     4'h2
`define PG_TIMER     4'h3
`define PG_TEMP      4'h4
`define OFS_ONOFF    3'h0
`define OFS_FLAGS    3'h1
`define OFS_STATUS   3'h3
`define ONOFF_RESET  8'h04
`define SYNC_IDLE    8'h7C
`define EDGE_IDLE    4'hF
`define B_TRUN       0
`define B_TRLD       1
`define B_REFRESH    2
`define B_RATE_LO    4
`define B_RATE_HI    5
`define F_ALARM      0
`define F_TIMER      1
`define S_PON        0
`define S_LOW1       1
`define ALARM_EN     7
`define HR_FMT       6
`define HR_PM        5
`define C_TLO        7
`define C_THI        8
`define C_TEMP       9
`define WATCH_N      7
`define EE_FIRST     7'h29
`define EE_LAST      7'h33
`define CLK_HZ       25000000
`define TICK_HZ      32
`define SCAN_LONG_S  16
`define REFRESH_S    3600
`endif

// >>> test/rtc_serial_checker.sv
`timescale 1ns/1ns
module rtc_serial_checker (
    input wire       clk,
    input wire       rst_n,
    input wire       cs_n,
    input wire       sda_out,
    input wire       so_oe_n,
    input wire       fast_detect,
    input wire       supply_above_second,
    input wire       ee_read_en,
    input wire [6:0] ee_addr,
    input wire       low_supply_first_status,
    input wire       thermo_active,
    input wire       temp_measure_req,
    input wire       power_on_status,
    input wire       countdown_zero_flag,
    input wire       timer_run_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence deselected; cs_n [*6]; endsequence
    sequence no_supply; (fast_detect && !supply_above_second) [*4]; endsequence
    sequence low_first; low_supply_first_status [*2]; endsequence
    a_so_float_idle: assert property (deselected |-> so_oe_n)
        else $error("serial output driven while deselected");
    a_sda_only_low: assert property (!sda_out)
        else $error("data line value not low");
    a_fast_held: assert property (no_supply |=> fast_detect)
        else $error("fast mode left without supply");
    a_load_range: assert property (ee_read_en |-> ee_addr >= 7'h29 && ee_addr <= 7'h33)
        else $error("load address out of range");
    a_thermo_forced_off: assert property (low_first |-> !thermo_active)
        else $error("thermometer active on low supply");
    a_measure_gated: assert property (temp_measure_req |-> thermo_active)
        else $error("measure while thermometer off");
    a_power_on_set: assert property ($rose(rst_n) |-> power_on_status)
        else $error("power on status clear after reset");
    a_zero_needs_run: assert property ($rose(countdown_zero_flag) |-> $past(timer_run_enable))
        else $error("zero flag while timer stopped");
endmodule
bind rtc_serial_core rtc_serial_checker rtc_serial_checker_inst (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sda_out(sda_out), .so_oe_n(so_oe_n),
    .fast_detect(fast_detect), .supply_above_second(supply_above_second), .ee_read_en(ee_read_en),
    .ee_addr(ee_addr), .low_supply_first_status(low_supply_first_status), .thermo_active(thermo_active),
    .temp_measure_req(temp_measure_req), .power_on_status(power_on_status),
    .countdown_zero_flag(countdown_zero_flag), .timer_run_enable(timer_run_enable)
);

// >>> test/rtc_serial_core_test.sv
`timescale 1ns/1ns
module rtc_serial_core_test;
    localparam TD = 64;
    logic       clk = 1'b0, rst_n = 1'b0, supply_above_first = 1'b1, supply_above_second = 1'b0;
    logic       thermo_enable = 1'b1, temp_meas_valid = 1'b0;
    logic [7:0] temp_meas = 8'h00;
    logic [31:0] seed = 32'h000012A8;
    logic [7:0] expq[$];
    logic [7:0] wv[7] = '{8'h30, 8'h45, 8'h12, 8'h15, 8'h03, 8'h06, 8'h24};
    int         pd[4] = '{TD, 4 * TD, 32 * TD, 64 * TD};
    int         miscompares = 0, comparisons = 0;
    wire        cs_n, sck, si, so, so_oe_n, rx_flip, ee_read_en, fast_detect, comp_calc_req, thermo_active;
    wire        so_pin = so_oe_n ? ~so : so;
    wire        timer_run_enable, timer_reload_select, timer_rate_hi, timer_rate_lo;
    wire        countdown_zero_flag, power_on_status, low_supply_first_status, alarm_match_flag;
    wire [7:0]  temp_value, rx_byte;
    rtc_serial_core #(.TICK_DIV(TD), .REFRESH_SECS(4)) rtc_serial_core_inst (
        .clk, .rst_n, .spi_mode(1'b1), .scl(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe_n(),
        .cs_n, .sck, .si, .so, .so_oe_n, .supply_above_first, .supply_above_second,
        .thermo_enable, .scan_period_select(1'b0), .temp_meas, .temp_meas_valid, .ee_read_en,
        .ee_addr(), .fast_detect, .voltage_check_req(), .temp_measure_req(), .comp_calc_req,
        .temp_value, .thermo_active, .timer_run_enable, .timer_reload_select, .timer_rate_hi,
        .timer_rate_lo, .alarm_match_flag, .countdown_zero_flag, .power_on_status, .low_supply_first_status
    );
    spi_host_model spi_host_model_inst (.cs_n, .sck, .si, .so(so_pin), .rx_byte, .rx_flip);
    always #20 clk = ~clk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return countdown_zero_flag;
            1: return comp_calc_req;
            2: return low_supply_first_status;
            3: return ee_read_en;
            default: return alarm_match_flag;
        endcase
    endfunction
    task automatic wait_hi(input int s, input int lim, output int n);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(posedge clk);
            #2;
            n++;
        end
        if (n >= lim) begin
            miscompares++;
            $display("wrong value wait %0d expected 1 seen 0", s);
            conclude();
        end
    endtask
    task automatic open_io(input [7:0] cmd);
        repeat (8) @(posedge clk);
        #2;
        spi_host_model_inst.open_frame(cmd);
    endtask
    task automatic put(input [7:0] tx, input [7:0] exp);
        expq.push_back(exp);
        spi_host_model_inst.shift(tx, 1'b1);
    endtask
    task automatic wr(input [6:0] a, input [7:0] d);
        open_io({1'b0, a});
        put(d, 8'h00);
        spi_host_model_inst.close_frame();
    endtask
    task automatic rd(input [6:0] a, input [7:0] e);
        open_io({1'b1, a});
        put(rnd(), e);
        spi_host_model_inst.close_frame();
    endtask
    always @(rx_flip) begin
        if ($time > 0) check("read byte", rx_byte, expq.pop_front());
    end
    initial begin
        int n;
        logic [7:0] v;
        repeat (8) @(posedge clk);
        #2 rst_n = 1'b1;
        check("power on", 8'(power_on_status), 8'h01);
        check("timer setup", 8'({timer_run_enable, timer_reload_select, timer_rate_hi, timer_rate_lo}), 8'h00);
        rd(7'h03, 8'h01);
        rd(7'h00, 8'h04);
        supply_above_second = 1'b1;
        wait_hi(3, 400, n);
        repeat (20) @(posedge clk);
        #2 check("fast mode", 8'({fast_detect, ee_read_en}), 8'h00);
        $display("done power up");
        open_io(8'h08);
        foreach (wv[i]) put(wv[i], 8'h00);
        spi_host_model_inst.close_frame();
        open_io(8'h88);
        foreach (wv[i]) put(rnd(), wv[i]);
        put(rnd(), 8'h00);
        put(rnd(), wv[0]);
        spi_host_model_inst.close_frame();
        wr(7'h14, 8'h83); // weekday compare only
        wait_hi(4, 2400, n);
        wr(7'h14, 8'h03);
        rd(7'h01, 8'h01);
        $display("done watch");
        v = rnd();
        temp_meas = v;
        temp_meas_valid = 1'b1;
        @(posedge clk);
        #2 temp_meas_valid = 1'b0;
        repeat (3) @(posedge clk);
        #2 check("sensor temp", temp_value, v);
        rd(7'h20, v);
        thermo_enable = 1'b0;
        v = rnd();
        wr(7'h20, v);
        wait_hi(1, 100, n);
        check("host temp", temp_value, v);
        thermo_enable = 1'b1;
        supply_above_first = 1'b0;
        wait_hi(2, 3000, n);
        repeat (2) @(posedge clk);
        #2 check("thermo off", 8'(thermo_active), 8'h00);
        rd(7'h03, 8'h03);
        $display("done temperature");
        for (int r = 0; r < 4; r++) begin
            wr(7'h18, 8'h02); // timer stopped while loaded
            wr(7'h00, {2'b00, 2'(r), 4'h5});
            wait_hi(0, 9000, n);
            check("timer period", 8'(n > pd[r] - 20 && n <= 2 * pd[r] + 8), 8'h01);
            wr(7'h00, 8'h04);
            rd(7'h18, 8'h00);
            wr(7'h01, 8'h00);
            rd(7'h01, 8'h00);
        end
        wr(7'h18, 8'h02);
        wr(7'h00, 8'h07);
        wait_hi(0, 400, n);
        rd(7'h18, 8'h02);
        wr(7'h00, 8'h04);
        $display("done timer");
        repeat (4) @(posedge clk);
        check("queue left", 8'(expq.size()), 8'h00);
        conclude();
    end
endmodule

// >>> test/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
    output reg       cs_n,
    output reg       sck,
    output reg       si,
    input  wire      so,
    output reg [7:0] rx_byte,
    output reg       rx_flip
);
    reg [7:0] sh;
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b1;
        sh = 8'h00;
        rx_byte = 8'h00;
        rx_flip = 1'b0;
    end
    task automatic open_frame(input [7:0] cmd);
        cs_n = 1'b0;
        #320;
        shift(cmd, 1'b0); // direction bit then seven address bits
    endtask
    task automatic shift(input [7:0] tx, input chk);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i]; // msb first, changed on fall
            #160;
            sck = 1'b1;
            sh = {sh[6:0], so}; // sampled on rise
            #160;
        end
        if (chk) begin
            rx_byte = sh;
            rx_flip = ~rx_flip;
        end
    endtask
    task automatic close_frame();
        #320;
        cs_n = 1'b1;
        si = ~si;
    endtask
endmodule
